// *** core/rcft_cfg.svh ***
// Register indices, field positions, reset values and fixed figures of the timer.
// Assumes inclusion by bare name from the timer package and the timer module.
`ifndef RCFT_CFG_SVH
`define RCFT_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define RCFT_IDX_DATA0    6'h20
`define RCFT_IDX_DATA3    6'h23
`define RCFT_IDX_COUNT0   6'h24
`define RCFT_IDX_COUNT3   6'h27
`define RCFT_IDX_MODE     6'h28
`define RCFT_IDX_CLKSEL   6'h29
`define RCFT_IDX_STATUS   6'h2a

// Mode control fields.
`define RCFT_MODE_RUN_BIT   0
`define RCFT_MODE_FREQ_BIT  1
`define RCFT_MODE_CAP_BIT   2

// Status fields.
`define RCFT_STAT_CAPTURE_FLAG_BIT  0
`define RCFT_STAT_OVF_BIT   1

// Reset values, counter wrap and limit values, and constant read bits.
`define RCFT_MODE_RESET     3'h0
`define RCFT_CLKSEL_RESET   2'h0
`define RCFT_COUNT_RESET    16'h0000
`define RCFT_DATA_RESET     16'h0000
`define RCFT_WRAP_VALUE     16'h0000
`define RCFT_COUNT_MAX      16'hffff
`define RCFT_MODE_FIXED     4'h8
`define RCFT_STAT_FIXED     4'hc

// Clock select codes.
`define RCFT_CLK_32K        2'h0
`define RCFT_CLK_700K       2'h1

// Measurement window length, 437/32768 s after the 64 Hz fall.
`define RCFT_WINDOW_NUM     437
`define RCFT_WINDOW_DEN     32768

`endif

// *** core/rcft_pkg.sv ***
// Types shared by the reload/capture/frequency timer.
// Assumes the constants header is on the include path.
`include "rcft_cfg.svh"

package rcft_pkg;

  typedef enum logic [1:0] {
    RCFT_MS_IDLE  = 2'b00,
    RCFT_MS_ARMED = 2'b01,
    RCFT_MS_COUNT = 2'b10,
    RCFT_MS_STOP  = 2'b11
  } rcft_meas_state_e;

  typedef logic [5:0] rcft_index_t;

endpackage

// *** core/rcft_timer.sv ***
// Reload/capture/frequency-measure 16-bit timer with an Avalon-MM register slave.
// Assumes one core clock; timer clocks, time base, window pulse and capture pin are
// asynchronous pins, while the converter interrupt and its mode level come from core logic.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "rcft_cfg.svh"

// How it works
// - 16-bit up-counter on selected clock falls.
// - Count split over four nibble registers.
// - Count nibble write also writes data nibble.
// - Data nibble write leaves count alone.
// - Interrupt pulse on every counter overflow.
// - Overflow toggles output on every overflow.
// - Mode bits both zero select auto reload.
// - Auto reload loads data on overflow.
// - Reload and capture modes count only while run bit set.
// - First increment on second clock fall.
// - One more increment after run cleared.
// - Converter interrupt clears run bit.
// - Capture mode wraps to zero, no reload.
// - Pin change copies count into data.
// - Capture sets status capture flag.
// - Flag set blocks further captures.
// - Status read clears capture flag.
// - Capture within one timer clock.
// - Frequency bit alone selects measurement mode.
// - Measurement starts at 64 Hz fall.
// - Window end clears bit, stops next fall.
// - Clock from 32k, 700k or external.
module rcft_timer #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              clk_32k_in,
  input  wire logic              clk_700k_in,
  input  wire logic              ext_count_clock,
  input  wire logic              time_base_64hz,
  input  wire logic              window_end_pulse,
  input  wire logic              capture_pin,
  input  wire logic              adc_done_irq,
  input  wire logic              adc_conv_mode,
  output logic                   overflow_irq,
  output logic                   overflow_toggle_out
);
  import rcft_pkg::*;

  localparam int NSYNC = 6;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] prev_reg;
  logic [15:0]      count_reg;
  logic [15:0]      data_reg;
  logic [2:0]       mode_reg;
  logic [1:0]       clksel_reg;
  logic             capture_flag_reg;
  logic             toggle_reg;
  logic             run_seen_reg;
  logic             cap_sample_reg;
  logic             cap_change_reg;
  logic             irq_reg;
  logic [31:0]      rdata_reg;
  logic             wait_reg;
  rcft_meas_state_e ms_reg;
  rcft_meas_state_e ms_next;

  logic        tick;
  logic        tb_fall;
  logic        win_rise;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  rcft_index_t idx;
  logic        run_bit;
  logic        freq_bit;
  logic        cap_bit;
  logic        auto_mode;
  logic        cap_mode;
  logic        meas_mode;
  logic        inc;
  logic        ovf;
  logic        count_wr;
  logic        data_wr;
  logic [1:0]  nib;
  logic        capture;
  logic [31:0] rd_value;

  assign async_in = {capture_pin, window_end_pulse, time_base_64hz,
                     ext_count_clock, clk_700k_in, clk_32k_in};

  // Every pin passes two flops; edge detectors look only at the second stage.
  // Each pin level must last at least two core cycles or an edge can be lost; the internal
  // clocks are far slower than the core clock, and an external clock must be as well.
  // The detector flops reset low, so a pin that idles high shows a rise after reset.
  // That is harmless, because only falls are counted on those pins.
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g]  <= 1'b0;
        end else begin
          sync1_reg[g] <= async_in[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g]  <= sync2_reg[g];
        end
      end
    end
  endgenerate

  // Falling edge of the selected timer clock.
  always_comb begin
    case (clksel_reg)
      `RCFT_CLK_32K:  tick = prev_reg[0] & ~sync2_reg[0];
      `RCFT_CLK_700K: tick = prev_reg[1] & ~sync2_reg[1];
      default:        tick = prev_reg[2] & ~sync2_reg[2];
    endcase
  end

  // The time base opens a window on its fall; the window pulse closes it on its rise.
  assign tb_fall  = prev_reg[3] & ~sync2_reg[3];
  assign win_rise = ~prev_reg[4] & sync2_reg[4];

  assign run_bit   = mode_reg[`RCFT_MODE_RUN_BIT];
  assign freq_bit  = mode_reg[`RCFT_MODE_FREQ_BIT];
  assign cap_bit   = mode_reg[`RCFT_MODE_CAP_BIT];
  assign auto_mode = ~freq_bit & ~cap_bit;
  assign cap_mode  = ~freq_bit & cap_bit;
  assign meas_mode = freq_bit & ~cap_bit;

  // Bus access: the request is answered one cycle after it is seen.
  // Only bits 3:0 of a word carry data; a write without byte lane 0 is answered and dropped.
  // The index decode ignores the two low address bits.
  assign req    = avs_read | avs_write;
  assign acc    = req & ~wait_reg;
  assign wr_acc = acc & avs_write & avs_byteenable[0];
  assign rd_acc = acc & avs_read;
  assign idx    = avs_address[ADDR_W-1:2];
  assign nib    = idx[1:0];
  assign count_wr = wr_acc && idx >= `RCFT_IDX_COUNT0 && idx <= `RCFT_IDX_COUNT3;
  assign data_wr  = wr_acc && idx >= `RCFT_IDX_DATA0 && idx <= `RCFT_IDX_DATA3;

  // Measurement modes other than the reserved pair count per the window state.
  // The stop state is tested first: hardware has already dropped the frequency bit there, so
  // the mode decode reads as auto reload, yet the closing tick of the window must still count.
  always_comb begin
    if (ms_reg == RCFT_MS_STOP) begin
      inc = tick;
    end else if (auto_mode || cap_mode) begin
      inc = tick & run_seen_reg;
    end else if (meas_mode) begin
      inc = tick & (ms_reg == RCFT_MS_COUNT);
    end else begin
      inc = 1'b0;
    end
  end

  assign ovf = inc & (count_reg == `RCFT_COUNT_MAX);

  // Capture needs the counter running and the flag clear.
  // A pin change seen while the flag is set is dropped, not held for later.
  assign capture = cap_mode & run_seen_reg & cap_change_reg & ~capture_flag_reg;

  // The run bit is seen one tick late, giving the delayed start and the extra tail count.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_seen_reg <= 1'b0;
    end else if (tick) begin
      run_seen_reg <= run_bit;
    end
  end

  // The pin is sampled on timer ticks; a change between samples is a one-cycle strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cap_sample_reg <= 1'b0;
      cap_change_reg <= 1'b0;
    end else begin
      cap_change_reg <= 1'b0;
      if (tick) begin
        cap_sample_reg <= sync2_reg[5];
        cap_change_reg <= sync2_reg[5] ^ cap_sample_reg;
      end
    end
  end

  // Counter. A software write wins over a tick in the same cycle.
  // Writing the count nibble by nibble while it runs can tear the value; stop the timer first.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_reg <= `RCFT_COUNT_RESET;
    end else if (count_wr) begin
      count_reg[nib*4 +: 4] <= avs_writedata[3:0];
    end else if (ovf) begin
      count_reg <= (auto_mode && ms_reg != RCFT_MS_STOP) ? data_reg : `RCFT_WRAP_VALUE;
    end else if (inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Data register. A capture outranks a software write.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_reg <= `RCFT_DATA_RESET;
    end else if (capture) begin
      data_reg <= count_reg;
    end else if (count_wr || data_wr) begin
      data_reg[nib*4 +: 4] <= avs_writedata[3:0];
    end
  end

  // Capture flag: set wins over the read clear; only a flag seen by the read is cleared.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      capture_flag_reg <= 1'b0;
    end else if (capture) begin
      capture_flag_reg <= 1'b1;
    end else if (rd_acc && idx == `RCFT_IDX_STATUS && rdata_reg[`RCFT_STAT_CAPTURE_FLAG_BIT]) begin
      capture_flag_reg <= 1'b0;
    end
  end

  // Overflow pulse, one core cycle long, in the cycle after the overflowing tick.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ovf;
    end
  end

  // Overflow toggle level for the port pin and the status register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      toggle_reg <= 1'b0;
    end else if (ovf) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // Measurement window sequencer.
  // Counting waits for a time-base fall after arming, so a window never starts part-way through a period.
  always_comb begin
    ms_next = ms_reg;
    case (ms_reg)
      RCFT_MS_IDLE: begin
        if (meas_mode) begin
          ms_next = RCFT_MS_ARMED;
        end
      end
      RCFT_MS_ARMED: begin
        if (!meas_mode) begin
          ms_next = RCFT_MS_IDLE;
        end else if (tb_fall) begin
          ms_next = RCFT_MS_COUNT;
        end
      end
      RCFT_MS_COUNT: begin
        if (win_rise) begin
          ms_next = RCFT_MS_STOP;
        end else if (!meas_mode) begin
          ms_next = RCFT_MS_IDLE;
        end
      end
      RCFT_MS_STOP: begin
        if (tick) begin
          ms_next = RCFT_MS_IDLE;
        end
      end
      default: begin
        ms_next = RCFT_MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ms_reg <= RCFT_MS_IDLE;
    end else begin
      ms_reg <= ms_next;
    end
  end

  // Mode control. Hardware clears of run and frequency bits yield to a write in the same
  // cycle, since software then states its newer intent.
  // The converter clear comes from core-clock logic, so it needs no synchroniser.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= `RCFT_MODE_RESET;
    end else if (wr_acc && idx == `RCFT_IDX_MODE) begin
      mode_reg <= avs_writedata[2:0];
    end else begin
      if (adc_conv_mode && adc_done_irq) begin
        mode_reg[`RCFT_MODE_RUN_BIT] <= 1'b0;
      end
      if (ms_reg == RCFT_MS_COUNT && win_rise) begin
        mode_reg[`RCFT_MODE_FREQ_BIT] <= 1'b0;
      end
    end
  end

  // Codes 2 and 3 both pick the external clock pin.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clksel_reg <= `RCFT_CLKSEL_RESET;
    end else if (wr_acc && idx == `RCFT_IDX_CLKSEL) begin
      clksel_reg <= avs_writedata[1:0];
    end
  end

  // Read mux; the clock select is write-only and unmapped words read zero.
  // Mode bit 3 and status bits 3:2 have no storage and always read as one.
  always_comb begin
    rd_value = 32'h0000_0000;
    if (idx >= `RCFT_IDX_DATA0 && idx <= `RCFT_IDX_DATA3) begin
      rd_value[3:0] = data_reg[nib*4 +: 4];
    end else if (idx >= `RCFT_IDX_COUNT0 && idx <= `RCFT_IDX_COUNT3) begin
      rd_value[3:0] = count_reg[nib*4 +: 4];
    end else if (idx == `RCFT_IDX_MODE) begin
      rd_value[3:0] = `RCFT_MODE_FIXED | {1'b0, mode_reg};
    end else if (idx == `RCFT_IDX_STATUS) begin
      rd_value[3:0] = `RCFT_STAT_FIXED | {2'b00, toggle_reg, capture_flag_reg};
    end
  end

  // Waitrequest idles high, drops for the single accept cycle, then rises again.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else if (req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data is latched as waitrequest drops and then holds until the next answer,
  // so the word stands at the edge where the master samples waitrequest low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && wait_reg) begin
      rdata_reg <= rd_value;
    end
  end

  assign avs_readdata        = rdata_reg;
  assign avs_waitrequest     = wait_reg;
  assign overflow_irq        = irq_reg;
  assign overflow_toggle_out = toggle_reg;

endmodule

`default_nettype wire

// *** dv/rcft_timer_chk.sv ***
// Checker for the timer's bus handshake, register read shapes and overflow outputs.
// Assumes it is bound to rcft_timer and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "rcft_cfg.svh"
module rcft_timer_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              overflow_irq,
  input wire logic              overflow_toggle_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // A read of one register index, up to the cycle where its answer stands.
  sequence s_rd(logic [5:0] idx);
    avs_read && avs_address[7:2] == idx && avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_UPPER_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:4] == 28'h0)
    else $error("read data upper bits not zero");
  AST_UNMAPPED: assert property (s_rd(6'h00) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (s_rd(`RCFT_IDX_STATUS) |->
    avs_readdata[3:1] == {2'b11, $past(overflow_toggle_out)})
    else $error("status read does not show toggle");
  AST_MODE: assert property (s_rd(`RCFT_IDX_MODE) |-> avs_readdata[3])
    else $error("mode read top bit not set");
  AST_IRQ_PULSE: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow interrupt longer than one cycle");
  AST_TOG_FLIP: assert property (overflow_irq |-> overflow_toggle_out != $past(overflow_toggle_out))
    else $error("toggle did not invert with overflow");
  AST_TOG_HOLD: assert property (!overflow_irq |-> $stable(overflow_toggle_out))
    else $error("toggle changed without overflow");
endmodule

bind rcft_timer rcft_timer_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk            (core_clk),
  .rst                 (rst),
  .avs_address         (avs_address),
  .avs_read            (avs_read),
  .avs_write           (avs_write),
  .avs_readdata        (avs_readdata),
  .avs_waitrequest     (avs_waitrequest),
  .overflow_irq        (overflow_irq),
  .overflow_toggle_out (overflow_toggle_out)
);
`default_nettype wire

// *** dv/test_reload_capture_freq_timer.sv ***
// Self-checking bench for the timer: bus tasks, reload, capture and measurement runs.
// Assumes the timer, its package and its checker are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module test_reload_capture_freq_timer;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        clk_32k_in = 1'b1;
  logic        clk_700k_in = 1'b1;
  logic        time_base_64hz = 1'b1;
  logic        window_end_pulse = 1'b0;
  logic        capture_pin = 1'b0;
  logic        adc_done_irq = 1'b0;
  logic        adc_conv_mode = 1'b0;
  logic        overflow_irq;
  logic        overflow_toggle_out;
  logic [1:0]  tsel = 2'h0;
  logic        ext_clk = 1'b1;
  logic [15:0] v;
  logic [15:0] d1;
  int          fails = 0;
  int          checked = 0;
  int          irqs = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (overflow_irq === 1'b1) irqs <= irqs + 1;

  rcft_timer DUT (
    .core_clk (core_clk), .rst (rst), .avs_address (avs_address), .avs_read (avs_read),
    .avs_write (avs_write), .avs_writedata (avs_writedata), .avs_byteenable (4'hf),
    .avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest),
    .clk_32k_in (clk_32k_in), .clk_700k_in (clk_700k_in), .ext_count_clock (ext_clk),
    .time_base_64hz (time_base_64hz), .window_end_pulse (window_end_pulse),
    .capture_pin (capture_pin), .adc_done_irq (adc_done_irq), .adc_conv_mode (adc_conv_mode),
    .overflow_irq (overflow_irq), .overflow_toggle_out (overflow_toggle_out)
  );

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Values seen right after the edge are the ones sampled at it, so no race with the slave.
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [3:0] wd,
                     output logic [3:0] rd);
    int n;
    @(posedge core_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {28'h0, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata[3:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 64) begin
      fails++;
      final_report();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [3:0] val);
    logic [3:0] r;
    acc(1'b1, idx, val, r);
  endtask

  task automatic chk(input logic [5:0] idx, input logic [3:0] exp);
    logic [3:0] r;
    acc(1'b0, idx, 4'h0, r);
    cmp16({12'h0, r}, {12'h0, exp});
  endtask

  task automatic w16(input logic [5:0] base, input logic [15:0] val);
    for (int i = 0; i < 4; i++) wr(base + 6'(i), val[4*i +: 4]);
  endtask

  task automatic r16(input logic [5:0] base, output logic [15:0] val);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, base + 6'(i), 4'h0, r);
      val[4*i +: 4] = r;
    end
  endtask

  // Each tick is one falling edge of the selected timer clock, slow enough for the syncs.
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge core_clk);
      case (tsel)
        2'h1:    clk_700k_in <= 1'b0;
        2'h2:    ext_clk <= 1'b0;
        default: clk_32k_in <= 1'b0;
      endcase
      repeat (8) @(posedge core_clk);
      clk_700k_in <= 1'b1;
      clk_32k_in  <= 1'b1;
      ext_clk     <= 1'b1;
      repeat (8) @(posedge core_clk);
    end
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    chk(6'h28, 4'h8);
    chk(6'h2a, 4'hc);
    chk(6'h00, 4'h0);
    w16(6'h24, 16'hfffe);
    chk(6'h20, 4'he);
    w16(6'h20, 16'h1230);
    r16(6'h24, v);
    cmp16(v, 16'hfffe);
    wr(6'h28, 4'h1);
    tk(3);
    wr(6'h28, 4'h0);
    tk(3);
    r16(6'h24, v);
    cmp16(v, 16'h1231);
    cmp16(16'(irqs), 16'h1);
    cmp16({15'h0, overflow_toggle_out}, 16'h1);
    adc_conv_mode <= 1'b1;
    wr(6'h28, 4'h1);
    adc_done_irq <= 1'b1;
    @(posedge core_clk);
    adc_done_irq <= 1'b0;
    chk(6'h28, 4'h8);
    adc_conv_mode <= 1'b0;
    w16(6'h24, 16'hffff);
    w16(6'h20, 16'h1234);
    wr(6'h28, 4'h5);
    tk(3);
    r16(6'h24, v);
    cmp16(v, 16'h0001);
    cmp16(16'(irqs), 16'h2);
    capture_pin <= ~capture_pin;
    tk(1);
    r16(6'h20, d1);
    cmp16({15'h0, d1 === 16'h0001 || d1 === 16'h0002}, 16'h1);
    capture_pin <= ~capture_pin;
    tk(1);
    r16(6'h20, v);
    cmp16(v, d1);
    chk(6'h2a, 4'hd);
    chk(6'h2a, 4'hc);
    capture_pin <= ~capture_pin;
    tk(1);
    chk(6'h2a, 4'hd);
    // The stop tick lands on the old clock so the tail count is taken before the count is zeroed for the window.
    wr(6'h28, 4'h0);
    tk(1);
    w16(6'h24, 16'h0000);
    wr(6'h29, 4'h1);
    tsel = 2'h1;
    wr(6'h28, 4'h2);
    tk(2);
    r16(6'h24, v);
    cmp16(v, 16'h0000);
    time_base_64hz <= 1'b0;
    tk(4);
    window_end_pulse <= 1'b1;
    tk(1);
    chk(6'h28, 4'h8);
    r16(6'h24, v);
    cmp16(v, 16'h0005);
    tk(2);
    r16(6'h24, d1);
    cmp16(d1, v);
    // External clock: two counts while running, one tail count after stop.
    w16(6'h24, 16'h0100);
    wr(6'h29, 4'h2);
    tsel = 2'h2;
    wr(6'h28, 4'h1);
    tk(3);
    wr(6'h28, 4'h0);
    tk(2);
    r16(6'h24, v);
    cmp16(v, 16'h0103);
    final_report();
  end
endmodule
`default_nettype wire
